/* src/devcap_regs.sv */
// device capabilities and device control registers of one switch port
// assumes a plain register port on CORE_CLK; events and messages are on the same clock
//
// How it works
// RULE1: endpoint L1 latency field always reads zero.
// RULE2: attention button, attention indicator, power indicator bits read zero.
// RULE3: role based error reporting bit reads one.
// RULE4: upstream port captures power value from slot power message; downstream stays zero.
// RULE5: power scale captured the same way; codes mean 1.0 down to 0.001.
// RULE6: four reset-zero enables gate correctable, nonfatal, fatal, unsupported reporting.
// RULE7: relaxed ordering enable reads zero; originated requests never set it.
// RULE8: payload codes 0..4 give 128..2048 bytes; codes 5..7 act as 128.
// RULE9: wide tag enable only matters in sequential tag debug: 0..255 versus 0..31.
// RULE10: phantom function and aux power enables read zero.
// RULE11: no snoop enable reads zero; originated never set, forwarded unchanged.
// RULE12: error flags set regardless of enables; cleared by writing one.
// RULE13: reserved bits read zero and ignore writes.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module devcap_regs
   import devcap_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // port configuration
   input wire logic UPSTREAM_PORT,
   // register port
   input wire logic [11:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // slot power message
   input wire logic PWR_MSG_VALID,
   input wire logic [7:0] PWR_MSG_VALUE,
   input wire logic [1:0] PWR_MSG_SCALE,
   // detected errors, one-cycle pulses: correctable, nonfatal, fatal, unsupported
   input wire logic [3:0] ERR_DETECT,
   // error reports gated by the enables
   output logic [3:0] ERR_REPORT,
   // originated transaction attributes
   output logic ORIG_RELAXED_ORDER,
   output logic ORIG_NO_SNOOP,
   // forwarded no snoop attribute
   input wire logic FWD_NO_SNOOP_IN,
   output logic FWD_NO_SNOOP_OUT,
   // payload limit and debug tag
   output logic [11:0] MAX_PAYLOAD_BYTES,
   input wire logic TAG_STEP,
   output logic [7:0] DEBUG_TAG,
   // interrupt
   output logic IRQ
);
   logic [3:0] report_en_reg;
   logic [2:0] mps_reg;
   logic wide_tag_reg;
   logic seq_tag_reg;
   logic [7:0] pwr_value_reg;
   logic [1:0] pwr_scale_reg;
   logic [3:0] err_stat_reg;
   logic [3:0] irq_stat_reg;
   logic [3:0] irq_mask_reg;
   logic [31:0] rdata_reg;
   logic [3:0] report_reg;
   logic fwd_ns_reg;
   logic [11:0] payload_reg;
   logic irq_reg;
   logic orig_ro_reg;
   logic orig_ns_reg;
   logic [31:0] rdata_next;
   logic [31:0] cap_word;
   logic [31:0] ctl_word;
   logic [11:0] payload_bytes;
   logic [7:0] tag;
   logic wr_ctl;
   logic wr_mask;
   logic wr_dbg;
   logic wr_evt;

   // upper half of the 0x048 word is the error status
   assign wr_ctl = WR && (ADDR == DEV_CTL_OFS);
   assign wr_mask = WR && (ADDR == IRQ_MASK_OFS);
   assign wr_dbg = WR && (ADDR == DEBUG_CTL_OFS);
   assign wr_evt = WR && (ADDR == EVT_STAT_OFS);

   // capability word, everything not listed reads zero
   always_comb begin
      cap_word = 32'h0000_0000; // see RULE13
      cap_word[CAP_MPAYLOAD_LSB +: 3] = CAP_MPAYLOAD_RST;
      cap_word[CAP_ETAG_BIT] = CAP_ETAG_RST;
      cap_word[CAP_L1_LAT_LSB +: 3] = CAP_L1_LAT_VAL; // see RULE1
      cap_word[CAP_ATTN_BTN_BIT] = 1'b0; // see RULE2
      cap_word[CAP_ATTN_IND_BIT] = 1'b0; // see RULE2
      cap_word[CAP_PWR_IND_BIT] = 1'b0; // see RULE2
      cap_word[CAP_ROLE_ERR_BIT] = CAP_ROLE_ERR_VAL; // see RULE3
      cap_word[CAP_PWR_VAL_LSB +: 8] = pwr_value_reg; // see RULE4
      cap_word[CAP_PWR_SCALE_LSB +: 2] = pwr_scale_reg; // see RULE5
   end

   always_comb begin
      ctl_word = 32'h0000_0000; // see RULE13
      ctl_word[CTL_CORR_BIT +: 4] = report_en_reg;
      ctl_word[CTL_RELAXED_BIT] = 1'b0; // see RULE7
      ctl_word[CTL_MPS_LSB +: 3] = mps_reg;
      ctl_word[CTL_WIDE_TAG_BIT] = wide_tag_reg;
      ctl_word[CTL_PHANTOM_BIT] = 1'b0; // see RULE10
      ctl_word[CTL_AUX_PM_BIT] = 1'b0; // see RULE10
      ctl_word[CTL_NO_SNOOP_BIT] = 1'b0; // see RULE11
      ctl_word[STAT_LSB +: 4] = err_stat_reg;
   end

   // read decode; unmapped addresses read zero
   always_comb begin
      if (ADDR == DEV_CAP_OFS) begin
         rdata_next = cap_word;
      end else if (ADDR == DEV_CTL_OFS) begin
         rdata_next = ctl_word;
      end else if (ADDR == IRQ_MASK_OFS) begin
         rdata_next = {28'h000_0000, irq_mask_reg};
      end else if (ADDR == DEBUG_CTL_OFS) begin
         rdata_next = {31'h0000_0000, seq_tag_reg};
      end else if (ADDR == EVT_STAT_OFS) begin
         rdata_next = {28'h000_0000, irq_stat_reg};
      end else begin
         rdata_next = 32'h0000_0000;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_reg <= 32'h0000_0000;
      end else if (RD) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // control fields; only writable bits are stored
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         report_en_reg <= CTL_REPORT_EN_RST;
         mps_reg <= CTL_MPS_RST;
         wide_tag_reg <= 1'b0;
      end else if (wr_ctl) begin
         report_en_reg <= WDATA[CTL_CORR_BIT +: 4]; // see RULE6
         mps_reg <= WDATA[CTL_MPS_LSB +: 3];
         wide_tag_reg <= WDATA[CTL_WIDE_TAG_BIT];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         seq_tag_reg <= 1'b0;
         irq_mask_reg <= 4'h0;
      end else begin
         if (wr_dbg) begin
            seq_tag_reg <= WDATA[0];
         end
         if (wr_mask) begin
            irq_mask_reg <= WDATA[3:0];
         end
      end
   end

   // slot power capture; downstream ports hold zero
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pwr_value_reg <= 8'h00;
         pwr_scale_reg <= 2'h0;
      end else if (!UPSTREAM_PORT) begin
         pwr_value_reg <= 8'h00; // see RULE4
         pwr_scale_reg <= 2'h0; // see RULE5
      end else if (PWR_MSG_VALID) begin
         pwr_value_reg <= PWR_MSG_VALUE; // see RULE4
         pwr_scale_reg <= PWR_MSG_SCALE; // see RULE5
      end
   end

   // error flags log regardless of enables; a new event beats a clear
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         err_stat_reg <= 4'h0;
      end else begin
         err_stat_reg <= (err_stat_reg & ~(wr_ctl ? WDATA[STAT_LSB +: 4] : 4'h0)) | ERR_DETECT; // see RULE12
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_stat_reg <= 4'h0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_evt ? WDATA[3:0] : 4'h0)) | ERR_DETECT;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // reporting gate, registered so outputs come from flops
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         report_reg <= 4'h0;
         fwd_ns_reg <= 1'b0;
         payload_reg <= PAYLOAD_128;
      end else begin
         report_reg <= ERR_DETECT & report_en_reg; // see RULE6
         fwd_ns_reg <= FWD_NO_SNOOP_IN; // see RULE11
         payload_reg <= payload_bytes; // see RULE8
      end
   end

   // originated attributes held in flops so every output leaves a register
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         orig_ro_reg <= 1'b0;
         orig_ns_reg <= 1'b0;
      end else begin
         orig_ro_reg <= 1'b0; // see RULE7
         orig_ns_reg <= 1'b0; // see RULE11
      end
   end

   payload_decode u_payload (
      .code(mps_reg),
      .bytes(payload_bytes)
   );

   tag_gen u_tag (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .enable(seq_tag_reg),
      .wide(wide_tag_reg), // see RULE9
      .step(TAG_STEP),
      .tag(tag)
   );

   assign RDATA = rdata_reg;
   assign ERR_REPORT = report_reg;
   // originated requests never carry these attributes
   assign ORIG_RELAXED_ORDER = orig_ro_reg; // see RULE7
   assign ORIG_NO_SNOOP = orig_ns_reg; // see RULE11
   assign FWD_NO_SNOOP_OUT = fwd_ns_reg;
   assign MAX_PAYLOAD_BYTES = payload_reg;
   assign DEBUG_TAG = tag;
   assign IRQ = irq_reg;
endmodule

/* src/devcap_pkg.sv */
// package for the device capabilities and device control register block
// assumes a 32-bit plain register port with byte offsets as printed
package devcap_pkg;
   // register offsets (byte addresses)
   localparam logic [11:0] DEV_CAP_OFS = 12'h044;
   localparam logic [11:0] DEV_CTL_OFS = 12'h048;
   localparam logic [11:0] ERR_STAT_OFS = 12'h04A;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h100;
   localparam logic [11:0] DEBUG_CTL_OFS = 12'h104;
   localparam logic [11:0] EVT_STAT_OFS = 12'h108;
   // capability field positions
   localparam int CAP_MPAYLOAD_LSB = 0;
   localparam int CAP_ETAG_BIT = 5;
   localparam int CAP_L1_LAT_LSB = 9;
   localparam int CAP_ATTN_BTN_BIT = 12;
   localparam int CAP_ATTN_IND_BIT = 13;
   localparam int CAP_PWR_IND_BIT = 14;
   localparam int CAP_ROLE_ERR_BIT = 15;
   localparam int CAP_PWR_VAL_LSB = 18;
   localparam int CAP_PWR_SCALE_LSB = 26;
   // capability values after reset
   localparam logic [2:0] CAP_MPAYLOAD_RST = 3'h4;
   localparam logic CAP_ETAG_RST = 1'b1;
   localparam logic [2:0] CAP_L1_LAT_VAL = 3'h0;
   localparam logic CAP_ROLE_ERR_VAL = 1'b1;
   // control field positions
   localparam int CTL_CORR_BIT = 0;
   localparam int CTL_NONFATAL_BIT = 1;
   localparam int CTL_FATAL_BIT = 2;
   localparam int CTL_UR_BIT = 3;
   localparam int CTL_RELAXED_BIT = 4;
   localparam int CTL_MPS_LSB = 5;
   localparam int CTL_WIDE_TAG_BIT = 8;
   localparam int CTL_PHANTOM_BIT = 9;
   localparam int CTL_AUX_PM_BIT = 10;
   localparam int CTL_NO_SNOOP_BIT = 11;
   localparam logic [3:0] CTL_REPORT_EN_RST = 4'h0;
   localparam logic [2:0] CTL_MPS_RST = 3'h0;
   // error status occupies bits 3:0 in the upper half of the 0x048 word
   localparam int STAT_LSB = 16;
   localparam int NUM_ERR = 4;
   // payload codes and byte counts
   localparam logic [2:0] MPS_MAX_CODE = 3'h4;
   localparam logic [11:0] PAYLOAD_128 = 12'h080;
   // tag ranges
   localparam logic [7:0] TAG_MAX_NARROW = 8'h1F;
   localparam logic [7:0] TAG_MAX_WIDE = 8'hFF;
endpackage

/* src/payload_decode.sv */
// maximum payload code to byte count decode
// assumes the code comes from the control register on the same clock
`timescale 1ns/1ps
module payload_decode
   import devcap_pkg::*;
(
   // selection
   input wire logic [2:0] code,
   // result
   output logic [11:0] bytes
);
   always_comb begin
      if (code > MPS_MAX_CODE) begin
         bytes = PAYLOAD_128; // see RULE8
      end else begin
         bytes = 12'(PAYLOAD_128 << code); // see RULE8
      end
   end
endmodule

/* src/tag_gen.sv */
// sequential debug tag generator
// assumes step comes from logic on the same clock
`timescale 1ns/1ps
module tag_gen
   import devcap_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic enable,
   input wire logic wide,
   input wire logic step,
   // tag
   output logic [7:0] tag
);
   logic [7:0] tag_reg;
   logic [7:0] limit;
   assign limit = wide ? TAG_MAX_WIDE : TAG_MAX_NARROW; // see RULE9
   assign tag = tag_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tag_reg <= 8'h00;
      end else if (!enable) begin
         tag_reg <= 8'h00;
      end else if (step) begin
         // wrap also catches a tag left above range when wide is turned off
         if (tag_reg >= limit) begin
            tag_reg <= 8'h00; // see RULE9
         end else begin
            tag_reg <= tag_reg + 8'h01;
         end
      end
   end
endmodule

/* verification/devcap_regs_properties.sv */
// concurrent checks on the port behaviour of devcap_regs
// assumes one core clock domain and RSTN as its asynchronous reset
`timescale 1ns/1ps
module devcap_regs_properties
   import devcap_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // watched ports
   input wire logic UPSTREAM_PORT,
   input wire logic [11:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [3:0] ERR_DETECT,
   input wire logic [3:0] ERR_REPORT,
   input wire logic ORIG_RELAXED_ORDER,
   input wire logic ORIG_NO_SNOOP,
   input wire logic FWD_NO_SNOOP_IN,
   input wire logic FWD_NO_SNOOP_OUT,
   input wire logic [11:0] MAX_PAYLOAD_BYTES
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   wire logic [2:0] wr_code = WDATA[7:5];
   // enables as last written, so the gate can be checked from the ports alone
   logic [3:0] en_seen;
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         en_seen <= CTL_REPORT_EN_RST;
      end else if (WR && ADDR == DEV_CTL_OFS) begin
         en_seen <= WDATA[CTL_CORR_BIT +: 4];
      end
   end
   a_no_relaxed: assert property (!ORIG_RELAXED_ORDER) else $error("relaxed order set");
   a_no_snoop_orig: assert property (!ORIG_NO_SNOOP) else $error("no snoop set");
   a_snoop_passes:
      assert property ($past(RSTN) |-> FWD_NO_SNOOP_OUT == $past(FWD_NO_SNOOP_IN)) else $error("no snoop altered");
   a_cap_fixed:
      assert property ($past(RD) && $past(ADDR) == DEV_CAP_OFS |-> RDATA[17:9] == 9'h040 && RDATA[31:28] == 4'h0)
      else $error("cap fixed bits wrong");
   a_ctl_fixed:
      assert property ($past(RD) && $past(ADDR) == DEV_CTL_OFS |-> !RDATA[4] && RDATA[15:9] == 7'h00
         && RDATA[31:20] == 12'h000) else $error("ctl fixed bits wrong");
   a_down_no_power:
      assert property (!UPSTREAM_PORT && $past(RD) && $past(ADDR) == DEV_CAP_OFS |-> RDATA[27:18] == 10'h000)
      else $error("downstream power nonzero");
   a_payload_reserved:
      assert property ($past(WR) && $past(ADDR) == DEV_CTL_OFS && $past(wr_code) > MPS_MAX_CODE
         |=> MAX_PAYLOAD_BYTES == PAYLOAD_128) else $error("reserved payload code");
   a_payload_legal:
      assert property (MAX_PAYLOAD_BYTES inside {12'h080, 12'h100, 12'h200, 12'h400, 12'h800})
      else $error("payload size illegal");
   a_report_gated:
      assert property ($past(RSTN) |-> ERR_REPORT == ($past(ERR_DETECT) & $past(en_seen)))
      else $error("report not gated");
endmodule
bind devcap_regs devcap_regs_properties u_props (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .UPSTREAM_PORT(UPSTREAM_PORT),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ERR_DETECT(ERR_DETECT), .ERR_REPORT(ERR_REPORT),
   .ORIG_RELAXED_ORDER(ORIG_RELAXED_ORDER), .ORIG_NO_SNOOP(ORIG_NO_SNOOP), .FWD_NO_SNOOP_IN(FWD_NO_SNOOP_IN),
   .FWD_NO_SNOOP_OUT(FWD_NO_SNOOP_OUT), .MAX_PAYLOAD_BYTES(MAX_PAYLOAD_BYTES));

/* verification/tb.sv */
// self-checking bench for devcap_regs
// assumes the one-cycle register port and pulse inputs of devcap_regs
`timescale 1ns/1ps
module tb;
   import devcap_pkg::*;
   logic CORE_CLK = 1'b0, RSTN = 1'b0, UPSTREAM_PORT = 1'b1, WR = 1'b0, RD = 1'b0;
   logic PWR_MSG_VALID = 1'b0, FWD_NO_SNOOP_IN = 1'b0, TAG_STEP = 1'b0;
   logic [11:0] ADDR = 12'h000, MAX_PAYLOAD_BYTES;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic [7:0] PWR_MSG_VALUE = 8'h00, DEBUG_TAG;
   logic [1:0] PWR_MSG_SCALE = 2'h0;
   logic [3:0] ERR_DETECT = 4'h0, ERR_REPORT;
   logic ORIG_RELAXED_ORDER, ORIG_NO_SNOOP, FWD_NO_SNOOP_OUT, IRQ;
   int error_cnt = 0, n_tests = 0;
   devcap_regs dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .UPSTREAM_PORT(UPSTREAM_PORT), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .PWR_MSG_VALID(PWR_MSG_VALID), .PWR_MSG_VALUE(PWR_MSG_VALUE),
      .PWR_MSG_SCALE(PWR_MSG_SCALE), .ERR_DETECT(ERR_DETECT), .ERR_REPORT(ERR_REPORT),
      .ORIG_RELAXED_ORDER(ORIG_RELAXED_ORDER), .ORIG_NO_SNOOP(ORIG_NO_SNOOP), .FWD_NO_SNOOP_IN(FWD_NO_SNOOP_IN),
      .FWD_NO_SNOOP_OUT(FWD_NO_SNOOP_OUT), .MAX_PAYLOAD_BYTES(MAX_PAYLOAD_BYTES), .TAG_STEP(TAG_STEP),
      .DEBUG_TAG(DEBUG_TAG), .IRQ(IRQ));
   initial begin
      forever #50 CORE_CLK = ~CORE_CLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      if (error_cnt == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // the forwarded attribute toggles with every write so the checker sees it move
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      FWD_NO_SNOOP_IN <= ~FWD_NO_SNOOP_IN;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      @(posedge CORE_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 chk(RDATA, exp, what);
   endtask
   task automatic err(input logic [3:0] v, input logic [3:0] exp);
      @(posedge CORE_CLK);
      ERR_DETECT <= v;
      @(posedge CORE_CLK);
      ERR_DETECT <= 4'h0;
      #1 chk({28'h0, ERR_REPORT}, {28'h0, exp}, "report");
   endtask
   task automatic pwr();
      @(posedge CORE_CLK);
      PWR_MSG_VALID <= 1'b1;
      PWR_MSG_VALUE <= 8'hA5;
      PWR_MSG_SCALE <= 2'h3;
      @(posedge CORE_CLK);
      PWR_MSG_VALID <= 1'b0;
   endtask
   task automatic step(input int n);
      @(posedge CORE_CLK);
      TAG_STEP <= 1'b1;
      repeat (n) @(posedge CORE_CLK);
      TAG_STEP <= 1'b0;
      #1;
   endtask
   task automatic tick_irq(input logic exp, input string what);
      @(posedge CORE_CLK);
      #1 chk({31'h0, IRQ}, {31'h0, exp}, what);
   endtask
   task automatic reset(input logic up);
      RSTN <= 1'b0;
      UPSTREAM_PORT <= up;
      repeat (5) @(posedge CORE_CLK);
      RSTN <= 1'b1;
   endtask
   initial begin
      #400000;
      error_cnt++;
      close_out();
   end
   initial begin
      reset(1'b1);
      chk({20'h0, MAX_PAYLOAD_BYTES}, 32'h80, "payload rst");
      rd(DEV_CAP_OFS, 32'h0000_8024, "cap");
      rd(DEV_CTL_OFS, 32'h0, "ctl rst");
      wr(DEV_CTL_OFS, 32'h0000_FFFF);
      // the write toggled the forwarded attribute once, so it must now show high
      #1 chk({30'h0, FWD_NO_SNOOP_OUT, ORIG_NO_SNOOP}, 32'h2, "no snoop");
      chk({31'h0, ORIG_RELAXED_ORDER}, 32'h0, "relaxed");
      rd(DEV_CTL_OFS, 32'h0000_01EF, "ctl ro");
      for (int c = 0; c < 8; c++) begin
         wr(DEV_CTL_OFS, 32'(c) << 5);
         @(posedge CORE_CLK);
         #1 chk({20'h0, MAX_PAYLOAD_BYTES}, c < 5 ? 32'h80 << c : 32'h80, "payload");
      end
      wr(IRQ_MASK_OFS, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(DEV_CTL_OFS, 32'h1 << i);
         err(4'hF, 4'h1 << i);
      end
      rd(DEV_CTL_OFS, 32'h000F_0008, "status");
      tick_irq(1'b0, "irq masked");
      wr(IRQ_MASK_OFS, 32'h2);
      tick_irq(1'b1, "irq");
      wr(EVT_STAT_OFS, 32'h2);
      tick_irq(1'b0, "irq clear");
      wr(DEV_CTL_OFS, 32'h0005_0000);
      rd(DEV_CTL_OFS, 32'h000A_0000, "w1c");
      err(4'h1, 4'h0);
      rd(DEV_CTL_OFS, 32'h000B_0000, "sticky");
      pwr();
      wr(DEV_CAP_OFS, 32'hFFFF_FFFF);
      rd(DEV_CAP_OFS, 32'h0E94_8024, "power");
      rd(12'h200, 32'h0, "unmapped");
      step(3);
      chk({24'h0, DEBUG_TAG}, 32'h0, "tag off");
      wr(DEBUG_CTL_OFS, 32'h1);
      step(33);
      chk({24'h0, DEBUG_TAG}, 32'h1, "narrow tag");
      wr(DEV_CTL_OFS, 32'h100);
      step(100);
      chk({24'h0, DEBUG_TAG}, 32'h65, "wide tag");
      reset(1'b0);
      pwr();
      rd(DEV_CAP_OFS, 32'h0000_8024, "downstream");
      close_out();
   end
endmodule
